// *** src/fpcr_top.sv ***
// flat panel control registers behind the serial programming port
`timescale 1ns/1ps
`default_nettype none
`include "fpcr_map.svh"

module fpcr_top
  import fpcr_pkg::*;
#(
  // arbitrary values, replace with the real part codes
  parameter logic [7:0] IDENT_CODE = `FPCR_IDENT_DEF,
  parameter logic [7:0] REV_CODE   = `FPCR_REV_DEF
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic ce_in,
  input  wire logic ser_sel_b_in,
  input  wire logic ser_clk_in,
  input  wire logic ser_data_in,
  input  wire logic panel_power_enable_input_in,
  output logic      ser_data_out,
  output logic      ser_data_oe_out,
  output logic      panel_power_out,
  output logic      panel_display_out,
  output logic      refresh_double_out,
  output logic      modulation_modified_out,
  output logic      data_24bit_out,
  output logic      pass_through_out,
  output logic      device_reset_out
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************

  // does a write with this map reach colour memory idx
  function automatic logic fpcr_colour_wr(input logic [1:0] map,
                                          input int unsigned idx);
    logic [1:0] want;
    want = 2'(idx + 1);
    return (map == fpcr_map_all) || (map == want);
  endfunction

  // which colour memory a read returns
  function automatic logic [1:0] fpcr_colour_rd(input logic [1:0] map);
    logic [1:0] sel;
    sel = 2'h0;
    if (map != fpcr_map_all) begin
      sel = map - 2'h1;
    end
    return sel;
  endfunction

  // index falls in the dither or modulation window
  function automatic logic fpcr_mem_hit(input logic [7:0] idx);
    return ((idx >= `FPCR_DITHER_FIRST) && (idx <= `FPCR_DITHER_LAST)) ||
           (idx >= `FPCR_FRM_FIRST);
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [3:0] pin_raw;
  logic [2:0] sync_ff [4];
  logic [3:0] filt_ff;
  logic [3:0] filt_d_ff;

  // bit 0 select, 1 serial clock, 2 serial data, 3 power input
  assign pin_raw = {panel_power_enable_input_in, ser_data_in,
                    ser_clk_in, ser_sel_b_in};

  // three flops, a change counts once the last two agree
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
          sync_ff[gi] <= ((`FPCR_PIN_IDLE >> gi & 4'h1) != 4'h0) ?
                         3'h7 : 3'h0;
          filt_ff[gi] <= (`FPCR_PIN_IDLE >> gi & 4'h1) != 4'h0;
          filt_d_ff[gi] <= (`FPCR_PIN_IDLE >> gi & 4'h1) != 4'h0;
        end else if (ce_in) begin
          sync_ff[gi] <= {sync_ff[gi][1:0], pin_raw[gi]};
          filt_d_ff[gi] <= filt_ff[gi];
          if (sync_ff[gi][1] == sync_ff[gi][2]) begin
            filt_ff[gi] <= sync_ff[gi][2];
          end
        end
      end
    end
  endgenerate

  logic sel_act;
  logic sclk_rise;
  logic sclk_fall;
  logic sdat;
  logic pwr_req;

  // edges seen on the filtered copies only
  assign sel_act   = ~filt_ff[0];
  assign sclk_rise = filt_ff[1] & ~filt_d_ff[1];
  assign sclk_fall = ~filt_ff[1] & filt_d_ff[1];
  assign sdat      = filt_ff[2];
  assign pwr_req   = filt_ff[3];

  // ****************************************************************
  // device reset request
  // ****************************************************************
  logic soft_rst_ff;
  logic core_rst_b;
  logic wr_go_ff;
  logic [7:0] addr_ff;
  logic [7:0] wdata_ff;

  // only the hard reset clears the request, so it lasts one cycle
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      soft_rst_ff <= 1'b0;
    end else if (ce_in) begin
      soft_rst_ff <= wr_go_ff && (addr_ff == `FPCR_IDX_CTRL) &&
                     wdata_ff[`FPCR_CTRL_RESET];
    end
  end

  // everything but the pin filters, the request, the reset strobe and the memory arrays follows the request
  assign core_rst_b = rst_b_in & ~soft_rst_ff;

  // ****************************************************************
  // serial frame sequencer
  // ****************************************************************
  fpcr_state_t state_ff;
  logic [4:0]  cnt_ff;
  logic [8:0]  shin_ff;
  logic        rw_ff;
  logic        hdr_done;
  logic        data_done;

  // ninth rising edge closes the read flag and index
  assign hdr_done  = (state_ff == fpcr_st_addr) && sel_act && sclk_rise &&
                     (cnt_ff == `FPCR_HDR_LAST);
  // eighth data edge closes the byte, one byte per frame
  assign data_done = (state_ff == fpcr_st_data) && sel_act && sclk_rise &&
                     (cnt_ff == `FPCR_DATA_LAST);

  // reset parks in done so a frame cut by reset is not resumed
  always_ff @(posedge clk_in) begin
    if (!core_rst_b) begin
      state_ff <= fpcr_st_done;
      cnt_ff   <= 5'h00;
      shin_ff  <= 9'h000;
      rw_ff    <= 1'b0;
      addr_ff  <= 8'h00;
    end else if (ce_in) begin
      case (state_ff)
        fpcr_st_idle: begin
          cnt_ff <= 5'h00;
          if (sel_act) begin
            state_ff <= fpcr_st_addr;
          end
        end
        fpcr_st_addr: begin
          if (!sel_act) begin
            state_ff <= fpcr_st_idle;
          end else if (sclk_rise) begin
            shin_ff <= {shin_ff[7:0], sdat};
            cnt_ff  <= cnt_ff + 5'h01;
            if (hdr_done) begin
              rw_ff    <= shin_ff[7];
              addr_ff  <= {shin_ff[6:0], sdat};
              cnt_ff   <= 5'h00;
              state_ff <= fpcr_st_data;
            end
          end
        end
        fpcr_st_data: begin
          if (!sel_act) begin
            state_ff <= fpcr_st_idle;
          end else if (sclk_rise) begin
            shin_ff <= {shin_ff[7:0], sdat};
            cnt_ff  <= cnt_ff + 5'h01;
            if (data_done) begin
              state_ff <= fpcr_st_done;
            end
          end
        end
        fpcr_st_done: begin
          if (!sel_act) begin
            state_ff <= fpcr_st_idle;
          end
        end
        default: begin
          state_ff <= fpcr_st_done;
        end
      endcase
    end
  end

  // write byte handed on as a one-cycle commit
  always_ff @(posedge clk_in) begin
    if (!core_rst_b) begin
      wr_go_ff <= 1'b0;
      wdata_ff <= 8'h00;
    end else if (ce_in) begin
      wr_go_ff <= data_done && !rw_ff;
      if (data_done && !rw_ff) begin
        wdata_ff <= {shin_ff[6:0], sdat};
      end
    end
  end

  // ****************************************************************
  // control and block select registers
  // ****************************************************************
  logic [7:0] ctrl_ff;
  logic [1:0] blk_ff;
  logic       locked;

  assign locked = ctrl_ff[`FPCR_CTRL_ENABLE];

  // control and block select stay writable while locked
  always_ff @(posedge clk_in) begin
    if (!core_rst_b) begin
      ctrl_ff <= `FPCR_CTRL_RST;
    end else if (ce_in) begin
      if (wr_go_ff && (addr_ff == `FPCR_IDX_CTRL)) begin
        // reset bit is a request, never stored
        ctrl_ff <= {1'b0, wdata_ff[6:0]};
      end
    end
  end

  // upper bits not stored, host keeps them zero anyway
  always_ff @(posedge clk_in) begin
    if (!core_rst_b) begin
      blk_ff <= `FPCR_BLKSEL_RST;
    end else if (ce_in) begin
      if (wr_go_ff && (addr_ff == `FPCR_IDX_BLKSEL)) begin
        blk_ff <= wdata_ff[`FPCR_BLKSEL_HI:`FPCR_BLKSEL_LO];
      end
    end
  end

  // ****************************************************************
  // colour memories
  // ****************************************************************
  logic [`FPCR_MEM_AW-1:0] mem_addr;
  logic [7:0]              mem_rd [3];
  logic [1:0]              map_sel;
  logic                    mem_wr_ok;

  assign map_sel = ctrl_ff[`FPCR_CTRL_MAP_HI:`FPCR_CTRL_MAP_LO];

  // dither bytes first, then the selected modulation block
  always_comb begin
    mem_addr = {4'h0, addr_ff[4:0]};
    if (addr_ff >= `FPCR_FRM_FIRST) begin
      mem_addr = `FPCR_FRM_OFS + {1'b0, blk_ff, addr_ff[5:0]};
    end
  end

  // locked writes dropped, memory keeps its bytes
  assign mem_wr_ok = wr_go_ff && fpcr_mem_hit(addr_ff) && !locked;

  generate
    for (gi = 0; gi < 3; gi++) begin : g_colour
      fpcr_mem u_mem (
        .clk_in      (clk_in),
        .rst_b_in    (core_rst_b),
        .ce_in       (ce_in),
        .wr_en_in    (mem_wr_ok && fpcr_colour_wr(map_sel, gi)),
        .addr_in     (mem_addr),
        .wr_data_in  (wdata_ff),
        .rd_data_out (mem_rd[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // read data path
  // ****************************************************************
  logic [7:0] rd_byte;
  logic [1:0] rd_wait_ff;
  logic [7:0] shout_ff;

  // reserved and locked memory indices read as zero
  always_comb begin
    if (addr_ff == `FPCR_IDX_IDENT) begin
      rd_byte = IDENT_CODE;
    end else if (addr_ff == `FPCR_IDX_REV) begin
      rd_byte = REV_CODE;
    end else if (addr_ff == `FPCR_IDX_CTRL) begin
      rd_byte = ctrl_ff;
    end else if (addr_ff == `FPCR_IDX_BLKSEL) begin
      rd_byte = {6'h00, blk_ff};
    end else if (fpcr_mem_hit(addr_ff) && !locked) begin
      rd_byte = mem_rd[fpcr_colour_rd(map_sel)];
    end else begin
      rd_byte = 8'h00;
    end
  end

  // two cycles wait for the registered memory read
  always_ff @(posedge clk_in) begin
    if (!core_rst_b) begin
      rd_wait_ff <= 2'h0;
    end else if (ce_in) begin
      rd_wait_ff <= {rd_wait_ff[0], hdr_done && shin_ff[7]};
    end
  end

  // byte goes out msb first, one bit per falling edge
  always_ff @(posedge clk_in) begin
    if (!core_rst_b) begin
      shout_ff     <= 8'h00;
      ser_data_out <= 1'b0;
    end else if (ce_in) begin
      if (rd_wait_ff[1]) begin
        shout_ff <= rd_byte;
      end else if ((state_ff == fpcr_st_data) && rw_ff && sclk_fall) begin
        ser_data_out <= shout_ff[7];
        shout_ff     <= {shout_ff[6:0], 1'b0};
      end
    end
  end

  // drive the data pin only inside the data phase of a read
  always_ff @(posedge clk_in) begin
    if (!core_rst_b) begin
      ser_data_oe_out <= 1'b0;
    end else if (ce_in) begin
      ser_data_oe_out <= (state_ff == fpcr_st_data) && rw_ff && sel_act;
    end
  end

  // ****************************************************************
  // panel controls
  // ****************************************************************

  // blank and unpowered until enabled, power input ignored before
  always_ff @(posedge clk_in) begin
    if (!core_rst_b) begin
      panel_display_out <= 1'b0;
      panel_power_out   <= 1'b0;
    end else if (ce_in) begin
      panel_display_out <= ctrl_ff[`FPCR_CTRL_ENABLE];
      panel_power_out   <= ctrl_ff[`FPCR_CTRL_ENABLE] & pwr_req;
    end
  end

  // mode decode, pass-through masks the format choice
  always_ff @(posedge clk_in) begin
    if (!core_rst_b) begin
      refresh_double_out      <= 1'b0;
      modulation_modified_out <= 1'b0;
      data_24bit_out          <= 1'b0;
      pass_through_out        <= 1'b0;
    end else if (ce_in) begin
      refresh_double_out      <= ctrl_ff[`FPCR_CTRL_REFRESH];
      modulation_modified_out <= ctrl_ff[`FPCR_CTRL_MODE];
      data_24bit_out          <= ctrl_ff[`FPCR_CTRL_FORMAT] &
                                 ~ctrl_ff[`FPCR_CTRL_PASS];
      pass_through_out        <= ctrl_ff[`FPCR_CTRL_PASS];
    end
  end

  // reset strobe for the rest of the device
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      device_reset_out <= 1'b0;
    end else if (ce_in) begin
      device_reset_out <= soft_rst_ff;
    end
  end

endmodule
`default_nettype wire

// *** src/fpcr_map.svh ***
// register map, field positions and counts of the flat panel control block
//
// Function
// - control bit 7 one resets device, colour memory contents kept
// - panel blank until enable bit set
// - enable zero: power input ignored, writes allowed
// - enable one: power needs external input too
// - enable one: only control, block select writable
// - locked writes leave contents unchanged
// - bit 5 selects single or double refresh
// - bits 4:3 route access to red/green/blue
// - map 00 writes all, reads red
// - bit 2 selects normal or modified modulation
// - bit 1 selects 16 or 24 bit data
// - bit 0 selects passive or pass-through output
// - pass-through overrides the format bit
// - read-only identification byte at index 0
// - read-only revision byte at index 1
// - all access one byte at a time
`ifndef FPCR_MAP_SVH
`define FPCR_MAP_SVH

// ****************************************************************
// register indices on the serial interface
// ****************************************************************
`define FPCR_IDX_IDENT     8'h00
`define FPCR_IDX_REV       8'h01
`define FPCR_IDX_CTRL      8'h02
`define FPCR_IDX_BLKSEL    8'h03
`define FPCR_DITHER_FIRST  8'h80
`define FPCR_DITHER_LAST   8'h9f
`define FPCR_FRM_FIRST     8'hc0

// ****************************************************************
// reset values and identity defaults
// ****************************************************************
`define FPCR_CTRL_RST      8'h00
`define FPCR_BLKSEL_RST    2'h0
// arbitrary values, stand-ins for the real part codes
`define FPCR_IDENT_DEF     8'h5a
`define FPCR_REV_DEF       8'h01

// ****************************************************************
// main_control and block select field positions
// ****************************************************************
`define FPCR_CTRL_RESET    7
`define FPCR_CTRL_ENABLE   6
`define FPCR_CTRL_REFRESH  5
`define FPCR_CTRL_MAP_HI   4
`define FPCR_CTRL_MAP_LO   3
`define FPCR_CTRL_MODE     2
`define FPCR_CTRL_FORMAT   1
`define FPCR_CTRL_PASS     0
`define FPCR_BLKSEL_HI     1
`define FPCR_BLKSEL_LO     0

// ****************************************************************
// memory layout and serial frame counts
// ****************************************************************
`define FPCR_MEM_DEPTH     288
`define FPCR_MEM_AW        9
`define FPCR_FRM_OFS       9'h020
`define FPCR_HDR_LAST      5'h08
`define FPCR_DATA_LAST     5'h07
`define FPCR_PIN_IDLE      4'h1

`endif

// *** src/fpcr_pkg.sv ***
// types shared by the flat panel control block
package fpcr_pkg;

  // serial frame sequencer, gray along idle-addr-data-done
  typedef enum logic [1:0] {
    fpcr_st_idle = 2'b00,
    fpcr_st_addr = 2'b01,
    fpcr_st_data = 2'b11,
    fpcr_st_done = 2'b10
  } fpcr_state_t;

  // colour memory routing held in control bits 4:3
  typedef enum logic [1:0] {
    fpcr_map_all   = 2'b00,
    fpcr_map_red   = 2'b01,
    fpcr_map_green = 2'b10,
    fpcr_map_blue  = 2'b11
  } fpcr_map_t;

endpackage

// *** src/fpcr_mem.sv ***
// byte memory for one colour: dither bytes then modulation blocks
`timescale 1ns/1ps
`default_nettype none
`include "fpcr_map.svh"

module fpcr_mem (
  input  wire logic                    clk_in,
  input  wire logic                    rst_b_in,
  input  wire logic                    ce_in,
  input  wire logic                    wr_en_in,
  input  wire logic [`FPCR_MEM_AW-1:0] addr_in,
  input  wire logic [7:0]              wr_data_in,
  output logic      [7:0]              rd_data_out
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0] mem_ff [`FPCR_MEM_DEPTH];

  // array itself has no reset, contents survive a soft reset
  always_ff @(posedge clk_in) begin
    if (ce_in && wr_en_in) begin
      mem_ff[addr_in] <= wr_data_in;
    end
  end

  // registered read, one cycle after the address
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rd_data_out <= 8'h00;
    end else if (ce_in) begin
      rd_data_out <= mem_ff[addr_in];
    end
  end

endmodule
`default_nettype wire

// *** dv/fpcr_host_model.sv ***
// host side model driving the serial programming port
`timescale 1ns/1ps
`default_nettype none

module fpcr_host_model (
  input  wire logic clk_in,
  input  wire logic dev_data_in,
  input  wire logic dev_oe_in,
  output var  logic sel_b_out,
  output var  logic sclk_out,
  output logic      line_out
);
  logic drv;

  // ****************************************************************
  // pin resolution
  // ****************************************************************
  // device wins the data pin while it drives, else the host level
  assign line_out = dev_oe_in ? dev_data_in : drv;

  // serial clock parks low and select high outside frames
  initial begin
    sel_b_out = 1'b1;
    sclk_out = 1'b0;
    drv = 1'b0;
  end

  // ****************************************************************
  // frame tasks, all pin changes at the falling clock edge
  // ****************************************************************
  task automatic gap(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // 8-cycle phases leave the pin filters a wide margin
  task automatic put_bit(input logic b, output logic s);
    drv = b;
    gap(8);
    s = line_out;
    sclk_out = 1'b1;
    gap(8);
    sclk_out = 1'b0;
  endtask

  // one byte per frame, direction bit then msb first
  task automatic frame(input logic rd, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [7:0] rdat);
    logic s;
    gap(1);
    sel_b_out = 1'b0;
    gap(8);
    put_bit(rd, s);
    for (int i = 7; i >= 0; i--) begin
      put_bit(idx[i], s);
    end
    for (int i = 7; i >= 0; i--) begin
      // released pin toggles so stale data never looks valid
      put_bit(rd ? ~drv : wd[i], s);
      rdat[i] = s;
    end
    gap(8);
    sel_b_out = 1'b1;
    drv = ~drv;
    gap(12);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    frame(1'b0, idx, d, x);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    frame(1'b1, idx, 8'h00, d);
  endtask
endmodule
`default_nettype wire

// *** dv/fpcr_top_chk.sv ***
// port-level assertions of the flat panel control block
`timescale 1ns/1ps
`default_nettype none

module fpcr_chk (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic ser_sel_b_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic panel_power_enable_input_in,
  input wire logic ser_data_out,
  input wire logic ser_data_oe_out,
  input wire logic panel_power_out,
  input wire logic panel_display_out,
  input wire logic refresh_double_out,
  input wire logic modulation_modified_out,
  input wire logic data_24bit_out,
  input wire logic pass_through_out,
  input wire logic device_reset_out
);
  logic [5:0] ctl_outs;

  // ****************************************************************
  // panel outputs gathered for compact checks
  // ****************************************************************
  assign ctl_outs = {panel_power_out, panel_display_out,
                     refresh_double_out, modulation_modified_out,
                     data_24bit_out, pass_through_out};

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  reset_blank_a: assert property (disable iff (1'b0)
    !rst_b_in |=> ctl_outs == 6'h00 && !device_reset_out && !ser_data_oe_out)
    else $error("outputs not cleared by reset");
  power_needs_enable_a: assert property (
    !panel_display_out |-> !panel_power_out)
    else $error("panel power without enable");
  power_follows_a: assert property (
    (panel_display_out && panel_power_enable_input_in)[*8] |-> panel_power_out)
    else $error("panel power missing");
  power_drops_a: assert property (
    (!panel_power_enable_input_in)[*8] |-> !panel_power_out)
    else $error("panel power without input");
  format_override_a: assert property (
    pass_through_out |-> !data_24bit_out)
    else $error("format bit not overridden");
  reset_pulse_a: assert property (
    device_reset_out |=> !device_reset_out)
    else $error("device reset pulse too long");
  reset_clears_a: assert property (
    device_reset_out |=> ctl_outs == 6'h00)
    else $error("control not cleared by device reset");
  oe_in_frame_a: assert property (
    $rose(ser_data_oe_out) |-> !ser_sel_b_in)
    else $error("data pin driven outside a frame");
  read_bit_hold_a: assert property (
    ser_data_oe_out && $past(ser_data_oe_out) && ser_clk_in
      && $past(ser_clk_in, 6) |-> $stable(ser_data_out))
    else $error("read bit moved in high phase");
endmodule

bind fpcr_top fpcr_chk chk_u (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
  .ser_sel_b_in(ser_sel_b_in), .ser_clk_in(ser_clk_in),
  .ser_data_in(ser_data_in),
  .panel_power_enable_input_in(panel_power_enable_input_in),
  .ser_data_out(ser_data_out), .ser_data_oe_out(ser_data_oe_out),
  .panel_power_out(panel_power_out), .panel_display_out(panel_display_out),
  .refresh_double_out(refresh_double_out),
  .modulation_modified_out(modulation_modified_out),
  .data_24bit_out(data_24bit_out), .pass_through_out(pass_through_out),
  .device_reset_out(device_reset_out));
`default_nettype wire

// *** dv/fpcr_tb_top.sv ***
// self-checking bench of the flat panel control block
`timescale 1ns/1ps
`default_nettype none

module fpcr_tb_top;
  localparam logic [7:0] IDENT = 8'h3c; // arbitrary code
  localparam logic [7:0] REV   = 8'h07; // arbitrary code
  logic       clk_in = 1'b0;
  logic       rst_b_in = 1'b0;
  logic       pwr_in = 1'b0;
  logic       sel_b, sclk, line, sdo, soe, dev_rst;
  logic [5:0] outs;
  logic [7:0] v;
  int         n_mismatch = 0;
  int         check_count = 0;
  int         pulses = 0;

  // ****************************************************************
  // clock, design and host
  // ****************************************************************
  always #2 clk_in = ~clk_in;

  // clock enable tied high: freezing is not part of the register rules
  fpcr_top #(.IDENT_CODE(IDENT), .REV_CODE(REV)) dut_u (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
    .ser_sel_b_in(sel_b), .ser_clk_in(sclk), .ser_data_in(line),
    .panel_power_enable_input_in(pwr_in), .ser_data_out(sdo),
    .ser_data_oe_out(soe), .panel_power_out(outs[5]),
    .panel_display_out(outs[4]), .refresh_double_out(outs[3]),
    .modulation_modified_out(outs[2]), .data_24bit_out(outs[1]),
    .pass_through_out(outs[0]), .device_reset_out(dev_rst));

  fpcr_host_model host_u (
    .clk_in(clk_in), .dev_data_in(sdo), .dev_oe_in(soe),
    .sel_b_out(sel_b), .sclk_out(sclk), .line_out(line));

  // count soft reset pulses as they happen
  always @(posedge clk_in) begin
    if (dev_rst === 1'b1) begin
      pulses++;
    end
  end

  // ****************************************************************
  // compare helpers
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    host_u.rd(idx, v);
    check(v, exp);
  endtask

  task automatic ck_outs(input logic [5:0] exp);
    check({2'h0, outs}, {2'h0, exp});
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    ck_outs(6'h00);
    rd_chk(8'h00, IDENT);
    rd_chk(8'h01, REV);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h00);
  endtask

  task automatic t_readonly();
    host_u.wr(8'h00, ~IDENT);
    host_u.wr(8'h01, ~REV);
    rd_chk(8'h00, IDENT);
    rd_chk(8'h01, REV);
  endtask

  task automatic t_fields();
    host_u.wr(8'h02, 8'h26);
    ck_outs(6'h0e);
    rd_chk(8'h02, 8'h26);
    host_u.wr(8'h02, 8'h02);
    ck_outs(6'h02);
    host_u.wr(8'h02, 8'h03);
    ck_outs(6'h01);
    host_u.wr(8'h02, 8'h00);
    ck_outs(6'h00);
  endtask

  task automatic t_maps();
    host_u.wr(8'h80, 8'ha5);
    for (int m = 1; m < 4; m++) begin
      host_u.wr(8'h02, 8'(m * 8));
      rd_chk(8'h80, 8'ha5);
      host_u.wr(8'h81, 8'(m * 17));
    end
    host_u.wr(8'h02, 8'h00);
    rd_chk(8'h81, 8'h11);
    for (int m = 1; m < 4; m++) begin
      host_u.wr(8'h02, 8'(m * 8));
      rd_chk(8'h81, 8'(m * 17));
    end
    // reserved block select bits written as zero
    host_u.wr(8'h02, 8'h08);
    host_u.wr(8'hc0, 8'h5c);
    host_u.wr(8'h03, 8'h01);
    host_u.wr(8'hc0, 8'hc5);
    rd_chk(8'h03, 8'h01);
    rd_chk(8'hc0, 8'hc5);
    host_u.wr(8'h03, 8'h00);
    rd_chk(8'hc0, 8'h5c);
  endtask

  task automatic t_lock();
    pwr_in = 1'b1;
    host_u.gap(10);
    ck_outs(6'h00);
    // enable set only once memories hold their patterns
    host_u.wr(8'h02, 8'h48);
    ck_outs(6'h30);
    pwr_in = 1'b0;
    host_u.gap(10);
    ck_outs(6'h10);
    rd_chk(8'h80, 8'h00);
    host_u.wr(8'h80, 8'hff);
    host_u.wr(8'h03, 8'h02);
    rd_chk(8'h03, 8'h02);
    host_u.wr(8'h02, 8'h08);
    rd_chk(8'h80, 8'ha5);
  endtask

  task automatic t_soft();
    host_u.wr(8'h02, 8'h26);
    check(8'(pulses), 8'h00);
    host_u.wr(8'h02, 8'ha6);
    check(8'(pulses), 8'h01);
    ck_outs(6'h00);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h00);
  endtask

  // ****************************************************************
  // sequence, watchdog and verdict
  // ****************************************************************
  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (10) @(negedge clk_in);
    t_reset();
    t_readonly();
    t_fields();
    t_maps();
    t_lock();
    t_soft();
    final_report();
  end

  // about 50 frames of 300 cycles each, so 60000 cycles is ample
  initial begin
    #240us;
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
